/* File: hisl_chk_sva.sv */
`timescale 1ns/10ps
`include "hisl_consts.vh"
module hisl_chk #(
  parameter [0:0] CAP_FIFO = 1'b1,
  parameter [0:0] CAP_CRB = 1'b1,
  parameter [0:0] CAP_MULTI_LOC = 1'b1,
  parameter [1:0] XFER_SIZE = 2'h3
) (
  input wire clk_in,
  input wire nrst_in,
  input wire reg_rd_in,
  input wire bus_abort_in,
  input wire [1:0] loc_cmd_in,
  input wire failure_mode_in,
  input wire hash_cmd_in,
  input wire spi_sel_n_in,
  input wire [31:0] reg_rdata_out,
  input wire hash_dropped_out,
  input wire loc_active_out,
  input wire [3:0] active_iface_type_out,
  input wire miso_out,
  input wire miso_oe_n_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  a_abort_read_ff: assert property (reg_rd_in && bus_abort_in |=> reg_rdata_out[7:0] == `HISL_ABORT_DATA)
    else $error("aborted read data");
  a_caps_fixed: assert property (reg_rd_in && !bus_abort_in |=> reg_rdata_out[14:13] == {CAP_CRB, CAP_FIFO})
    else $error("capability bits");
  a_size_loc: assert property (reg_rd_in && !bus_abort_in |=> reg_rdata_out[12:8] == {XFER_SIZE, 2'h0, CAP_MULTI_LOC})
    else $error("size or locality bits");
  a_type_code: assert property (active_iface_type_out inside {4'h0, 4'h1, 4'hf})
    else $error("type code");
  a_hash_drop: assert property (failure_mode_in && hash_cmd_in |=> hash_dropped_out)
    else $error("hash not dropped");
  a_hash_cause: assert property (hash_dropped_out |-> $past(failure_mode_in && hash_cmd_in))
    else $error("stray hash drop");
  a_abort_high: assert property (!miso_oe_n_out |-> miso_out)
    else $error("abort level");
  a_abort_hold: assert property (!miso_oe_n_out && !spi_sel_n_in |=> !miso_oe_n_out)
    else $error("abort released early");
  a_deselect_free: assert property (spi_sel_n_in [*5] |-> miso_oe_n_out)
    else $error("drive after deselect");
  a_grant_req: assert property ($rose(loc_active_out) |-> $past(loc_cmd_in, 2) == `HISL_LOC_REQ)
    else $error("grant without request");
  c_abort_rd: cover property (reg_rd_in && bus_abort_in);
  c_grant: cover property ($rose(loc_active_out));
  c_hash: cover property (hash_dropped_out);
endmodule // hisl_chk
bind hisl_top hisl_chk #(.CAP_FIFO(CAP_FIFO), .CAP_CRB(CAP_CRB), .CAP_MULTI_LOC(CAP_MULTI_LOC),
  .XFER_SIZE(XFER_SIZE)) chk_u (.clk_in, .nrst_in, .reg_rd_in, .bus_abort_in, .loc_cmd_in, .failure_mode_in,
  .hash_cmd_in, .spi_sel_n_in, .reg_rdata_out, .hash_dropped_out, .loc_active_out, .active_iface_type_out,
  .miso_out, .miso_oe_n_out);

/* File: hisl_consts.vh */
`ifndef HISL_CONSTS_VH
`define HISL_CONSTS_VH
// Field positions of the interface identity/select register
`define HISL_TYPE_LSB 0
`define HISL_TYPE_MSB 3
`define HISL_VER_LSB 4
`define HISL_VER_MSB 7
`define HISL_MLOC_BIT 8
`define HISL_XFER_LSB 11
`define HISL_XFER_MSB 12
`define HISL_FIFO_IFACE_CAP_BIT 13
`define HISL_CMD_BUFFER_IFACE_CAP_BIT 14
`define HISL_SEL_LSB 17
`define HISL_SEL_MSB 18
`define HISL_LOCK_BIT 19
// Interface type codes
`define HISL_TYPE_FIFO 4'h0
`define HISL_TYPE_CRB 4'h1
`define HISL_TYPE_LEGACY 4'hf
// Selector codes
`define HISL_SEL_FIFO 2'h0
`define HISL_SEL_CRB 2'h1
`define HISL_SEL_RSVD 2'h3
// Transfer size codes
`define HISL_XFER_4 2'h0
`define HISL_XFER_8 2'h1
`define HISL_XFER_32 2'h2
`define HISL_XFER_64 2'h3
// Aborted reads return all ones in the low byte
`define HISL_ABORT_DATA 8'hff
// Locality action codes on loc_cmd_in
`define HISL_LOC_NONE 2'h0
`define HISL_LOC_REQ 2'h1
`define HISL_LOC_REL 2'h2
`define HISL_LOC_SEIZE 2'h3
`define HISL_NLOC 5
`endif

/* File: hisl_spi_host.sv */
`timescale 1ns/10ps
module hisl_spi_host #(
  parameter [7:0] LEN = 8'h14
) (
  input wire clk_in,
  input wire go_in,
  input wire rd_in,
  output reg sel_n_out = 1'b1,
  output reg is_read_out = 1'b0
);
  reg [7:0] cnt_r = 8'h0;
  // Direction line has no pull, so it toggles while deselected
  always @(posedge clk_in)
    if (go_in && sel_n_out)
    begin
      sel_n_out <= 1'b0;
      is_read_out <= rd_in;
      cnt_r <= LEN;
    end
    else if (!sel_n_out)
    begin
      cnt_r <= cnt_r - 8'h1;
      if (cnt_r == 8'h1)
        sel_n_out <= 1'b1;
    end
    else
      is_read_out <= ~is_read_out;
endmodule // hisl_spi_host

/* File: hisl_top.v */
`timescale 1ns/10ps
`include "hisl_consts.vh"

// Function
// - Multi-locality bit reflects five-locality support
// - Single-locality part lacks seize, keeps protocol
// - FIFO capability bit read-only
// - Buffer capability bit read-only
// - Read-only transfer-size field in identity register
// - Selector changes only with both caps, unlocked
// - Locked selector discards writes
// - Type FIFO: 00 ignored, 01 selects buffer
// - Type buffer: 11 ignored, 00 selects FIFO
// - Legacy type ignores all selector writes
// - Lock set-only, needs both capabilities
// - Lock cleared on platform init event; a lock write on that cycle wins
// - Idle device grants first requester
// - Release grants highest pending locality
// - Seize only from lower locality
// - LPC abort leaves no internal effect
// - Aborted LPC read returns FFh
// - SPI read abort holds MISO high until deselect
// - SPI write abort drives MISO high, drops data
// - Wait states may precede SPI abort
// - Failure mode drops hash commands silently
// - Failure mode keeps registers and localities working
// - Transfer-size encoding
// - Active interface type encoding
// - Reset pin rising edge is platform init
module hisl_top #(
  parameter CAP_FIFO = 1'b1,
  parameter CAP_CRB = 1'b1,
  parameter CAP_MULTI_LOC = 1'b1,
  parameter [1:0] XFER_SIZE = 2'h3,
  parameter LEGACY_ONLY = 1'b0,
  parameter [3:0] BOOT_TYPE = 4'h0
) (
  input wire clk_in,
  input wire nrst_in,
  input wire bus_rst_n_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_wdata_in,
  input wire bus_abort_in,
  input wire [1:0] loc_cmd_in,
  input wire [2:0] loc_num_in,
  input wire loc_withdraw_in,
  input wire failure_mode_in,
  input wire hash_cmd_in,
  input wire spi_sel_n_in,
  input wire spi_is_read_in,
  input wire spi_abort_req_in,
  input wire spi_decode_busy_in,
  output reg [31:0] reg_rdata_out,
  output reg reg_rdata_valid_out,
  output reg hash_dropped_out,
  output reg [4:0] loc_pending_out,
  output reg [2:0] active_loc_out,
  output reg loc_active_out,
  output reg [3:0] active_iface_type_out,
  output reg miso_out,
  output reg miso_oe_n_out,
  output reg spi_wait_out,
  output reg spi_drop_data_out
);

  // Two-flop synchronisers for the pins from the host bus domain
  reg rst_pin_s1_r;
  reg rst_pin_s2_r;
  reg rst_pin_d_r;
  reg sel_s1_r;
  reg sel_s2_r;
  wire init_evt;
  wire both_caps;

  reg [3:0] active_iface_type_r;
  reg [1:0] iface_select_r;
  reg iface_select_lock_r;
  reg [4:0] pend_r;
  reg [4:0] pend_nxt;
  reg [2:0] act_r;
  reg [2:0] act_nxt;
  reg act_v_r;
  reg act_v_nxt;
  reg init_seen_r;

  // One-hot states of the SPI abort sequencer
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_ABORT = 3'b100;
  reg [2:0] spi_st_r;

  // Highest set bit of a pending mask
  function [2:0] hisl_top_hi;
    input [4:0] m;
    integer i;
    begin
      hisl_top_hi = 3'h0;
      for (i = 0; i < `HISL_NLOC; i = i + 1)
        if (m[i])
          hisl_top_hi = i[2:0];
    end
  endfunction

  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      // Idle high, so leaving reset with the pin high shows no false rising edge
      rst_pin_s1_r <= 1'b1;
      rst_pin_s2_r <= 1'b1;
      rst_pin_d_r <= 1'b1;
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
    end
    else
    begin
      rst_pin_s1_r <= bus_rst_n_in;
      rst_pin_s2_r <= rst_pin_s1_r;
      rst_pin_d_r <= rst_pin_s2_r;
      sel_s1_r <= spi_sel_n_in;
      sel_s2_r <= sel_s1_r;
    end
  end

  assign init_evt = rst_pin_s2_r & ~rst_pin_d_r;
  // Selector and lock may only move when both interfaces are offered
  assign both_caps = CAP_FIFO & CAP_CRB;

  // Identity register: selector choice lands in the type at the next init
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      active_iface_type_r <= 4'h0;
      iface_select_r <= 2'h0;
      iface_select_lock_r <= 1'b0;
      init_seen_r <= 1'b0;
    end
    else if (!init_seen_r)
    begin
      // Strap-like defaults loaded one cycle after reset release
      init_seen_r <= 1'b1;
      active_iface_type_r <= LEGACY_ONLY ? `HISL_TYPE_LEGACY : BOOT_TYPE;
      iface_select_r <= (BOOT_TYPE == `HISL_TYPE_CRB) ? `HISL_SEL_CRB : `HISL_SEL_FIFO;
    end
    else if (init_evt)
    begin
      iface_select_lock_r <= 1'b0;
      // A lock write landing on the init cycle still wins over the clear
      if (reg_wr_in && !bus_abort_in && both_caps && reg_wdata_in[`HISL_LOCK_BIT])
        iface_select_lock_r <= 1'b1;
      if (active_iface_type_r != `HISL_TYPE_LEGACY)
        active_iface_type_r <= (iface_select_r == `HISL_SEL_CRB) ? `HISL_TYPE_CRB : `HISL_TYPE_FIFO;
    end
    else if (reg_wr_in && !bus_abort_in)
    begin
      // Capability and type bits are never stored from the bus
      // Ignored selector codes leave a pending choice untouched
      if (both_caps && !iface_select_lock_r && active_iface_type_r != `HISL_TYPE_LEGACY)
      begin
        if (active_iface_type_r == `HISL_TYPE_FIFO &&
            reg_wdata_in[`HISL_SEL_MSB:`HISL_SEL_LSB] == `HISL_SEL_CRB)
          iface_select_r <= `HISL_SEL_CRB;
        else if (active_iface_type_r == `HISL_TYPE_CRB &&
                 reg_wdata_in[`HISL_SEL_MSB:`HISL_SEL_LSB] == `HISL_SEL_FIFO)
          iface_select_r <= `HISL_SEL_FIFO;
      end
      // Lock applied after the selector in the same write
      if (both_caps && reg_wdata_in[`HISL_LOCK_BIT])
        iface_select_lock_r <= 1'b1;
    end
  end

  // Locality arbitration; single-locality parts accept only locality 0
  always @*
  begin
    pend_nxt = pend_r;
    act_nxt = act_r;
    act_v_nxt = act_v_r;
    if (!bus_abort_in && (CAP_MULTI_LOC || loc_num_in == 3'h0) && loc_num_in < 3'h5)
    begin
      // A request wins over a withdrawal arriving in the same cycle
      if (loc_withdraw_in)
        pend_nxt[loc_num_in] = 1'b0;
      if (loc_cmd_in == `HISL_LOC_REQ && !(act_v_r && act_r == loc_num_in))
        pend_nxt[loc_num_in] = 1'b1;
      if (loc_cmd_in == `HISL_LOC_SEIZE && CAP_MULTI_LOC && act_v_r && loc_num_in > act_r)
      begin
        act_nxt = loc_num_in;
        pend_nxt[loc_num_in] = 1'b0;
      end
      else if (loc_cmd_in == `HISL_LOC_REL && act_v_r && loc_num_in == act_r)
        act_v_nxt = 1'b0;
    end
    // An idle device grants a request in the cycle it arrives
    if (!act_v_nxt && pend_nxt != 5'h00)
    begin
      act_nxt = hisl_top_hi(pend_nxt);
      act_v_nxt = 1'b1;
      pend_nxt[act_nxt] = 1'b0;
    end
  end

  always @(posedge clk_in)
  begin
    if (!nrst_in || init_evt)
    begin
      pend_r <= 5'h00;
      act_r <= 3'h0;
      act_v_r <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      act_r <= act_nxt;
      act_v_r <= act_v_nxt;
    end
  end

  // SPI abort: optional wait, then MISO held high until deselect
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      spi_st_r <= ST_IDLE;
      miso_out <= 1'b0;
      miso_oe_n_out <= 1'b1;
      spi_wait_out <= 1'b0;
      spi_drop_data_out <= 1'b0;
    end
    else
    begin
      case (spi_st_r)
        ST_IDLE:
        begin
          miso_oe_n_out <= 1'b1;
          spi_drop_data_out <= 1'b0;
          if (!sel_s2_r && spi_decode_busy_in)
          begin
            spi_st_r <= ST_WAIT;
            spi_wait_out <= 1'b1;
          end
          else if (!sel_s2_r && spi_abort_req_in)
          begin
            spi_st_r <= ST_ABORT;
            miso_out <= 1'b1;
            miso_oe_n_out <= 1'b0;
            spi_drop_data_out <= ~spi_is_read_in;
          end
        end
        ST_WAIT:
        begin
          if (sel_s2_r)
          begin
            spi_st_r <= ST_IDLE;
            spi_wait_out <= 1'b0;
          end
          // Abort is only issued once decoding has finished
          else if (!spi_decode_busy_in)
          begin
            spi_wait_out <= 1'b0;
            if (spi_abort_req_in)
            begin
              spi_st_r <= ST_ABORT;
              miso_out <= 1'b1;
              miso_oe_n_out <= 1'b0;
              spi_drop_data_out <= ~spi_is_read_in;
            end
            else
              spi_st_r <= ST_IDLE;
          end
        end
        ST_ABORT:
        begin
          miso_out <= 1'b1;
          if (sel_s2_r)
          begin
            spi_st_r <= ST_IDLE;
            miso_out <= 1'b0;
            miso_oe_n_out <= 1'b1;
            spi_drop_data_out <= 1'b0;
          end
        end
        default:
        begin
          // Release MISO so a corrupted state cannot keep driving the pin
          spi_st_r <= ST_IDLE;
          spi_wait_out <= 1'b0;
          miso_out <= 1'b0;
          miso_oe_n_out <= 1'b1;
        end
      endcase
    end
  end

  // Read data and outputs
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      reg_rdata_out <= 32'h00000000;
      reg_rdata_valid_out <= 1'b0;
      hash_dropped_out <= 1'b0;
      loc_pending_out <= 5'h00;
      active_loc_out <= 3'h0;
      loc_active_out <= 1'b0;
      active_iface_type_out <= 4'h0;
    end
    else
    begin
      reg_rdata_valid_out <= reg_rd_in;
      // Aborted reads answer all ones in the low byte, as a master abort would
      if (reg_rd_in && bus_abort_in)
        reg_rdata_out <= {24'h000000, `HISL_ABORT_DATA};
      else if (reg_rd_in)
      begin
        reg_rdata_out <= 32'h00000000;
        reg_rdata_out[`HISL_TYPE_MSB:`HISL_TYPE_LSB] <= active_iface_type_r;
        reg_rdata_out[`HISL_VER_MSB:`HISL_VER_LSB] <= {3'h0, active_iface_type_r == `HISL_TYPE_CRB};
        reg_rdata_out[`HISL_MLOC_BIT] <= CAP_MULTI_LOC;
        reg_rdata_out[`HISL_XFER_MSB:`HISL_XFER_LSB] <= XFER_SIZE;
        reg_rdata_out[`HISL_FIFO_IFACE_CAP_BIT] <= CAP_FIFO;
        reg_rdata_out[`HISL_CMD_BUFFER_IFACE_CAP_BIT] <= CAP_CRB;
        reg_rdata_out[`HISL_SEL_MSB:`HISL_SEL_LSB] <= iface_select_r;
        reg_rdata_out[`HISL_LOCK_BIT] <= iface_select_lock_r;
      end
      // Hash commands complete at once in failure mode, never stalling
      hash_dropped_out <= hash_cmd_in & failure_mode_in;
      // Status outputs trail the internal state by one cycle
      loc_pending_out <= pend_r;
      active_loc_out <= act_r;
      loc_active_out <= act_v_r;
      active_iface_type_out <= active_iface_type_r;
    end
  end

endmodule // hisl_top

/* File: hisl_top_tb.sv */
`timescale 1ns/10ps
`include "hisl_consts.vh"
module hisl_top_tb;
  reg clk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg bus_rst_n_in = 1'b1;
  reg reg_wr_in = 1'b0;
  reg reg_rd_in = 1'b0;
  reg [31:0] reg_wdata_in = 32'h0;
  reg bus_abort_in = 1'b0;
  reg [1:0] loc_cmd_in = 2'h0;
  reg [2:0] loc_num_in = 3'h0;
  reg loc_withdraw_in = 1'b0;
  reg failure_mode_in = 1'b0;
  reg hash_cmd_in = 1'b0;
  reg spi_abort_req_in = 1'b0;
  reg spi_decode_busy_in = 1'b0;
  reg go = 1'b0;
  reg rd = 1'b0;
  reg [31:0] seed = 32'h37ed7164;
  reg [31:0] q[$];
  integer error_cnt = 0;
  integer n_checks = 0;
  integer cyc = 0;
  wire spi_sel_n_in;
  wire spi_is_read_in;
  wire [31:0] reg_rdata_out;
  wire reg_rdata_valid_out;
  wire hash_dropped_out;
  wire [4:0] loc_pending_out;
  wire [2:0] active_loc_out;
  wire loc_active_out;
  wire [3:0] active_iface_type_out;
  wire miso_out;
  wire miso_oe_n_out;
  wire spi_wait_out;
  wire spi_drop_data_out;
  wire [31:0] rdata2;
  wire [2:0] loc2;
  wire act2;
  hisl_top dut_u (.clk_in, .nrst_in, .bus_rst_n_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .bus_abort_in,
    .loc_cmd_in, .loc_num_in, .loc_withdraw_in, .failure_mode_in, .hash_cmd_in, .spi_sel_n_in,
    .spi_is_read_in, .spi_abort_req_in, .spi_decode_busy_in, .reg_rdata_out, .reg_rdata_valid_out,
    .hash_dropped_out, .loc_pending_out, .active_loc_out, .loc_active_out, .active_iface_type_out,
    .miso_out, .miso_oe_n_out, .spi_wait_out, .spi_drop_data_out);
  hisl_spi_host host_u (.clk_in, .go_in(go), .rd_in(rd), .sel_n_out(spi_sel_n_in), .is_read_out(spi_is_read_in));
  // Legacy, single-locality, FIFO-only variant shares every input
  hisl_top #(.CAP_CRB(1'b0), .CAP_MULTI_LOC(1'b0), .LEGACY_ONLY(1'b1)) dut_lg_u (.clk_in, .nrst_in, .bus_rst_n_in,
    .reg_wr_in, .reg_rd_in, .reg_wdata_in, .bus_abort_in, .loc_cmd_in, .loc_num_in, .loc_withdraw_in,
    .failure_mode_in, .hash_cmd_in, .spi_sel_n_in, .spi_is_read_in, .spi_abort_req_in, .spi_decode_busy_in,
    .reg_rdata_out(rdata2), .reg_rdata_valid_out(), .hash_dropped_out(), .loc_pending_out(),
    .active_loc_out(loc2), .loc_active_out(act2), .active_iface_type_out(), .miso_out(), .miso_oe_n_out(),
    .spi_wait_out(), .spi_drop_data_out());
  always #12.5 clk_in = ~clk_in;
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task close_out;
  begin
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // Read-only bits get random data to show writes leave them alone
  task wr(input [1:0] s, input l, input ab);
  begin
    seed = lfsr(seed);
    @(negedge clk_in);
    reg_wr_in = 1'b1;
    bus_abort_in = ab;
    reg_wdata_in = seed & 32'hfff1ffff | {12'h0, l, s, 17'h0};
    @(negedge clk_in);
    reg_wr_in = 1'b0;
    bus_abort_in = 1'b0;
  end
  endtask
  task rdx(input [31:0] e, input ab);
  begin
    @(negedge clk_in);
    q.push_back(e);
    reg_rd_in = 1'b1;
    bus_abort_in = ab;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    bus_abort_in = 1'b0;
  end
  endtask
  task init;
  begin
    bus_rst_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    bus_rst_n_in = 1'b1;
    repeat (6) @(negedge clk_in);
  end
  endtask
  task loc(input [1:0] c, input [2:0] n);
  begin
    @(negedge clk_in);
    loc_cmd_in = c;
    loc_num_in = n;
    @(negedge clk_in);
    loc_cmd_in = `HISL_LOC_NONE;
    repeat (2) @(negedge clk_in);
  end
  endtask
  always @(negedge clk_in)
    if (reg_rdata_valid_out === 1'b1)
      chk("rdata", q.size() ? q.pop_front() : 32'hxxxxxxxx, reg_rdata_out);
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  initial
  begin
    repeat (4) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rdx(32'h7900, 1'b0);
    chk("rdata2", 32'h380f, rdata2);
    wr(2'h1, 1'b0, 1'b1);
    rdx(32'h7900, 1'b0);
    rdx(32'hff, 1'b1);
    wr(2'h0, 1'b0, 1'b0);
    rdx(32'h7900, 1'b0);
    wr(2'h1, 1'b0, 1'b0);
    rdx(32'h27900, 1'b0);
    wr(2'h1, 1'b1, 1'b0);
    wr(2'h0, 1'b0, 1'b0);
    rdx(32'ha7900, 1'b0);
    chk("rdata2", 32'h380f, rdata2);
    $display("register test done");
    init;
    chk("type", 32'h1, active_iface_type_out);
    rdx(32'h27911, 1'b0);
    wr(2'h3, 1'b0, 1'b0);
    rdx(32'h27911, 1'b0);
    wr(2'h0, 1'b0, 1'b0);
    init;
    rdx(32'h7900, 1'b0);
    $display("init test done");
    loc(`HISL_LOC_REQ, 3'h1);
    loc(`HISL_LOC_REQ, 3'h3);
    loc(`HISL_LOC_REQ, 3'h2);
    chk("loc", 32'h9, {loc_active_out, active_loc_out});
    chk("pend", 32'hc, loc_pending_out);
    chk("loc2", 32'h0, {act2, loc2});
    loc(`HISL_LOC_REL, 3'h1);
    chk("loc", 32'hb, {loc_active_out, active_loc_out});
    chk("pend", 32'h4, loc_pending_out);
    loc(`HISL_LOC_SEIZE, 3'h1);
    chk("loc", 32'hb, {loc_active_out, active_loc_out});
    failure_mode_in = 1'b1;
    loc(`HISL_LOC_SEIZE, 3'h4);
    chk("loc", 32'hc, {loc_active_out, active_loc_out});
    loc(`HISL_LOC_REQ, 3'h0);
    chk("loc2", 32'h8, {act2, loc2});
    chk("pend", 32'h5, loc_pending_out);
    @(negedge clk_in);
    loc_withdraw_in = 1'b1;
    loc_num_in = 3'h2;
    @(negedge clk_in);
    loc_withdraw_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("pend", 32'h1, loc_pending_out);
    rdx(32'h7900, 1'b0);
    hash_cmd_in = 1'b1;
    @(negedge clk_in);
    hash_cmd_in = 1'b0;
    chk("hash", 32'h1, hash_dropped_out);
    failure_mode_in = 1'b0;
    $display("locality test done");
    rd = 1'b1;
    go = 1'b1;
    @(negedge clk_in);
    go = 1'b0;
    spi_decode_busy_in = 1'b1;
    repeat (5) @(negedge clk_in);
    chk("wait", 32'h1, spi_wait_out);
    spi_decode_busy_in = 1'b0;
    spi_abort_req_in = 1'b1;
    repeat (3) @(negedge clk_in);
    spi_abort_req_in = 1'b0;
    chk("miso", 32'h1, {miso_oe_n_out, miso_out});
    repeat (4) @(negedge clk_in);
    chk("miso", 32'h1, {miso_oe_n_out, miso_out});
    repeat (16) @(negedge clk_in);
    chk("oe", 32'h1, miso_oe_n_out);
    rd = 1'b0;
    go = 1'b1;
    @(negedge clk_in);
    go = 1'b0;
    spi_abort_req_in = 1'b1;
    repeat (6) @(negedge clk_in);
    spi_abort_req_in = 1'b0;
    chk("drop", 32'h3, {spi_drop_data_out, miso_out});
    repeat (24) @(negedge clk_in);
    $display("spi test done");
    close_out;
  end
endmodule // hisl_top_tb
